// File: cmio_regs.svh
// register map, field layout and function codes of the motion io points
// Functional notes
// RQ1: active high: high pin means logical one
// RQ2: active low: low pin means logical one
// RQ3: standard set: four points, sink/source in, sink out
// RQ4: enhanced set: eight points, banks 1-4, 9-12
// RQ5: single point or group access, polarity too
// RQ6: setup gives point, function, polarity, sink/source
// RQ7: code 0 general input, bank readable
// RQ8: code 1 homing input
// RQ9: codes 2, 3 positive, negative limit
// RQ10: code 4 starts program at address one
// RQ11: code 5 soft stop, decelerate, halt
// RQ12: code 6 pause, next activation resumes
// RQ13: codes 7, 8 jog, only with enable
// RQ14: code 11 acts as break character
// RQ15: remote encoder reserves second bank
// RQ16: standard outputs always sinking
// RQ17: nine input, four output dedicated functions
// RQ18: inputs synchronised before use
`ifndef CMIO_REGS_SVH
`define CMIO_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CMIO_ADR_SETUP 8'h00
`define CMIO_ADR_POL 8'h04
`define CMIO_ADR_OUT 8'h08
`define CMIO_ADR_IN 8'h0c
`define CMIO_ADR_CTRL 8'h10
`define CMIO_ADR_STAT 8'h14

// ----------------------------------------------------------------
// setup and control register fields
// ----------------------------------------------------------------
`define CMIO_SU_PT_LSB 0
`define CMIO_SU_PT_MSB 3
`define CMIO_SU_FN_LSB 8
`define CMIO_SU_FN_MSB 12
`define CMIO_SU_POL_BIT 16
`define CMIO_SU_SRC_BIT 20
`define CMIO_PT_GROUP 4'h0
`define CMIO_CTRL_JOG_BIT 0

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define CMIO_FN_GP_IN 5'h00
`define CMIO_FN_HOME 5'h01
`define CMIO_FN_LIM_POS 5'h02
`define CMIO_FN_LIM_NEG 5'h03
`define CMIO_FN_START 5'h04
`define CMIO_FN_SSTOP 5'h05
`define CMIO_FN_PAUSE 5'h06
`define CMIO_FN_JOG_POS 5'h07
`define CMIO_FN_JOG_NEG 5'h08
`define CMIO_FN_RESET 5'h0b
`define CMIO_FN_GP_OUT 5'h10
`define CMIO_FN_MOVING 5'h11
`define CMIO_FN_FAULT 5'h12
`define CMIO_FN_STALL 5'h13
`define CMIO_FN_VCHG 5'h14

// ----------------------------------------------------------------
// reset values and fixed figures
// ----------------------------------------------------------------
`define CMIO_START_ADDR 8'h01
`define CMIO_FN_RST 5'h00
`define CMIO_POL_RST 8'hff
`define CMIO_BANK_PTS 4

`endif

// File: cmio_pkg.sv
// types shared by the motion io point logic
package cmio_pkg;
    typedef logic [4:0] cmio_fn_t;
    typedef logic [7:0] cmio_adr_t;
    typedef enum logic {CMIO_RUNNING, CMIO_PAUSED} cmio_pause_t;
endpackage

// File: cmio_point.sv
// one io point: input synchroniser, polarity and pin drive
`timescale 1ns/1ps
`default_nettype none
module cmio_point (
    input wire logic ref_clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic pin_i, // pin level
    input wire logic pol_i, // 1 active high, 0 active low
    input wire logic is_out_i, // point is an output
    input wire logic src_i, // sourcing drive allowed
    input wire logic lvl_i, // logical output value
    output logic pin_o, // pin drive value
    output logic pin_oe_o, // pin drive enable
    output logic val_o, // logical input value
    output logic rise_o // activation pulse
);
    logic sync1, sync2, prev;
    logic next_sync1, next_sync2, next_prev;

    // ----------------------------------------------------------------
    // input path
    // ----------------------------------------------------------------
    // two stage synchroniser, polarity after it
    assign val_o = pol_i ? sync2 : ~sync2; // [RQ1] [RQ2] [RQ18]
    assign rise_o = val_o & ~prev;

    always_comb begin
        next_sync1 = pin_i;
        next_sync2 = sync1;
        next_prev = val_o;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b1;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    // ----------------------------------------------------------------
    // output path
    // ----------------------------------------------------------------
    // sinking pulls low only; sourcing drives both levels
    always_comb begin
        pin_o = 1'b0;
        pin_oe_o = 1'b0;
        if (is_out_i) begin
            if (src_i) begin
                pin_o = pol_i ? lvl_i : ~lvl_i; // [RQ1] [RQ2]
                pin_oe_o = 1'b1;
            end else begin
                pin_oe_o = pol_i ? ~lvl_i : lvl_i; // [RQ16]
            end
        end
    end

    in_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!$past(rst_i) && !$past(rst_i, 2)) |-> val_o == (pol_i ? $past(pin_i, 2)
        : !$past(pin_i, 2))) // [RQ18]
        else $error("input value not polarity of pin two cycles back");

    sink_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (is_out_i && !src_i) |-> (pin_o == 1'b0 && pin_oe_o == (lvl_i != pol_i))) // [RQ16]
        else $error("sinking output drove high or wrong level");
endmodule
`default_nettype wire

// File: cmio_top.sv
// motion io points with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "cmio_regs.svh"
module cmio_top #(
    parameter bit ENHANCED = 1'b1, // eight points in two banks
    parameter bit REMOTE_ENC = 1'b0, // second bank kept for encoder
    parameter int NPT = 8 // point slots, two banks of four
) (
    input wire logic ref_clk_i, // 200 MHz system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire cmio_pkg::cmio_adr_t wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [NPT-1:0] io_pin_i, // point pin levels
    output logic [NPT-1:0] io_pin_o, // point pin drive values
    output logic [NPT-1:0] io_pin_oe_o, // point pin drive enables
    input wire logic moving_i, // motor moving
    input wire logic fault_i, // error present
    input wire logic stall_i, // stall detected
    input wire logic vel_chg_i, // velocity changing
    output logic home_o, // homing input active
    output logic limit_pos_o, // positive limit active
    output logic limit_neg_o, // negative limit active
    output logic start_o, // start program pulse
    output logic [7:0] start_addr_o, // program address to run
    output logic soft_stop_o, // soft stop pulse
    output logic pause_o, // program and motion paused
    output logic jog_pos_o, // jog positive at max velocity
    output logic jog_neg_o, // jog negative at max velocity
    output logic break_o // break character equivalent pulse
);
    import cmio_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // point number to slot: 1-4 -> 0-3, 9-12 -> 4-7
    function automatic logic [3:0] pt_slot(input logic [3:0] num);
        logic [3:0] r;
        r = 4'h0;
        if (num >= 4'h1 && num <= 4'h4) begin
            r = {1'b1, 3'(num - 4'h1)}; // [RQ4]
        end else if (num >= 4'h9 && num <= 4'hc) begin
            r = {1'b1, 3'(num - 4'h5)}; // [RQ4]
        end
        return r;
    endfunction

    // slot usable in this build
    function automatic logic slot_ok(input int idx);
        logic r;
        r = (idx < `CMIO_BANK_PTS) || (ENHANCED && !REMOTE_ENC); // [RQ3] [RQ15]
        return r;
    endfunction

    // nine dedicated inputs, four dedicated outputs, two general
    function automatic logic fn_ok(input cmio_fn_t fn);
        logic r;
        unique case (fn)
            `CMIO_FN_GP_IN, `CMIO_FN_HOME, `CMIO_FN_LIM_POS, `CMIO_FN_LIM_NEG,
            `CMIO_FN_START, `CMIO_FN_SSTOP, `CMIO_FN_PAUSE, `CMIO_FN_JOG_POS,
            `CMIO_FN_JOG_NEG, `CMIO_FN_RESET, `CMIO_FN_GP_OUT, `CMIO_FN_MOVING,
            `CMIO_FN_FAULT, `CMIO_FN_STALL, `CMIO_FN_VCHG: r = 1'b1; // [RQ17]
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic fn_out(input cmio_fn_t fn);
        logic r;
        r = (fn >= `CMIO_FN_GP_OUT);
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cmio_fn_t cfg_fn [NPT];
    cmio_fn_t next_cfg_fn [NPT];
    logic [NPT-1:0] cfg_pol, next_cfg_pol;
    logic [NPT-1:0] cfg_src, next_cfg_src;
    logic [NPT-1:0] gp_out, next_gp_out;
    logic jog_en, next_jog_en;
    logic [3:0] last_pt, next_last_pt;
    logic ack, next_ack;
    logic [31:0] rdat, next_rdat;
    cmio_pause_t pause_st, next_pause_st;
    logic start_q, next_start_q;
    logic sstop_q, next_sstop_q;
    logic brk_q, next_brk_q;

    logic [NPT-1:0] val, rise, is_out, src_ok, lvl;
    logic [3:0] wr_slot, rd_slot;
    logic req, wr, su_wr, pt_ok;
    cmio_fn_t wr_fn;

    // ----------------------------------------------------------------
    // point instances
    // ----------------------------------------------------------------
    // per point direction, drive style and logical output
    always_comb begin
        for (int i = 0; i < NPT; i++) begin
            is_out[i] = slot_ok(i) && fn_out(cfg_fn[i]);
            src_ok[i] = ENHANCED && cfg_src[i]; // [RQ16]
            unique case (cfg_fn[i])
                `CMIO_FN_GP_OUT: lvl[i] = gp_out[i];
                `CMIO_FN_MOVING: lvl[i] = moving_i;
                `CMIO_FN_FAULT: lvl[i] = fault_i;
                `CMIO_FN_STALL: lvl[i] = stall_i;
                `CMIO_FN_VCHG: lvl[i] = vel_chg_i;
                default: lvl[i] = 1'b0;
            endcase
        end
    end

    for (genvar g = 0; g < NPT; g++) begin : g_pt
        cmio_point u_pt (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .pin_i(io_pin_i[g]),
            .pol_i(cfg_pol[g]),
            .is_out_i(is_out[g]),
            .src_i(src_ok[g]),
            .lvl_i(lvl[g]),
            .pin_o(io_pin_o[g]),
            .pin_oe_o(io_pin_oe_o[g]),
            .val_o(val[g]),
            .rise_o(rise[g])
        );
    end

    // ----------------------------------------------------------------
    // dedicated input functions
    // ----------------------------------------------------------------
    // any enabled input point carrying the code acts
    function automatic logic [NPT-1:0] fn_hit(input cmio_fn_t fn, input logic [NPT-1:0] v);
        logic [NPT-1:0] r;
        for (int i = 0; i < NPT; i++) begin
            r[i] = slot_ok(i) && (cfg_fn[i] == fn) && v[i];
        end
        return r;
    endfunction

    // level functions, re-evaluated when the configuration alone changes
    always_comb begin
        home_o = |fn_hit(`CMIO_FN_HOME, val); // [RQ8]
        limit_pos_o = |fn_hit(`CMIO_FN_LIM_POS, val); // [RQ9]
        limit_neg_o = |fn_hit(`CMIO_FN_LIM_NEG, val); // [RQ9]
        jog_pos_o = jog_en && |fn_hit(`CMIO_FN_JOG_POS, val); // [RQ13]
        jog_neg_o = jog_en && |fn_hit(`CMIO_FN_JOG_NEG, val); // [RQ13]
    end
    assign start_addr_o = `CMIO_START_ADDR; // [RQ10]
    assign start_o = start_q;
    assign soft_stop_o = sstop_q;
    assign break_o = brk_q;
    assign pause_o = (pause_st == CMIO_PAUSED);

    // activation pulses and pause toggle
    always_comb begin
        next_start_q = |fn_hit(`CMIO_FN_START, rise); // [RQ10]
        next_sstop_q = |fn_hit(`CMIO_FN_SSTOP, rise); // [RQ11]
        next_brk_q = |fn_hit(`CMIO_FN_RESET, rise); // [RQ14]
        next_pause_st = pause_st;
        if (next_sstop_q || next_brk_q) begin
            next_pause_st = CMIO_RUNNING; // [RQ11]
        end else if (|fn_hit(`CMIO_FN_PAUSE, rise)) begin
            unique case (pause_st)
                CMIO_RUNNING: next_pause_st = CMIO_PAUSED; // [RQ12]
                CMIO_PAUSED: next_pause_st = CMIO_RUNNING; // [RQ12]
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
            sstop_q <= 1'b0;
            brk_q <= 1'b0;
            pause_st <= CMIO_RUNNING;
        end else begin
            start_q <= next_start_q;
            sstop_q <= next_sstop_q;
            brk_q <= next_brk_q;
            pause_st <= next_pause_st;
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !ack;
    assign wr = req && wb_we_i;
    assign su_wr = wr && (wb_adr_i == `CMIO_ADR_SETUP) && (wb_sel_i[2:0] == 3'h7);
    assign wr_slot = pt_slot(wb_dat_i[`CMIO_SU_PT_MSB:`CMIO_SU_PT_LSB]);
    assign wr_fn = wb_dat_i[`CMIO_SU_FN_MSB:`CMIO_SU_FN_LSB];
    // only group or a usable point number is accepted
    assign pt_ok = (wb_dat_i[`CMIO_SU_PT_MSB:`CMIO_SU_PT_LSB] == `CMIO_PT_GROUP) ||
        (wr_slot[3] && slot_ok(int'(wr_slot[2:0]))); // [RQ4] [RQ15]
    assign rd_slot = pt_slot(last_pt);
    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;

    // register writes: setup per point or whole group
    always_comb begin
        next_cfg_fn = cfg_fn;
        next_cfg_pol = cfg_pol;
        next_cfg_src = cfg_src;
        next_gp_out = gp_out;
        next_jog_en = jog_en;
        next_last_pt = last_pt;
        if (su_wr && fn_ok(wr_fn) && pt_ok) begin // [RQ6]
            next_last_pt = wb_dat_i[`CMIO_SU_PT_MSB:`CMIO_SU_PT_LSB];
            for (int i = 0; i < NPT; i++) begin
                if (slot_ok(i) && ((wr_slot[3] && wr_slot[2:0] == 3'(i)) ||
                    next_last_pt == `CMIO_PT_GROUP)) begin // [RQ5] [RQ6]
                    next_cfg_fn[i] = wr_fn;
                    next_cfg_pol[i] = wb_dat_i[`CMIO_SU_POL_BIT];
                    next_cfg_src[i] = wb_dat_i[`CMIO_SU_SRC_BIT];
                end
            end
        end
        if (wr && wb_sel_i[0]) begin
            for (int i = 0; i < NPT; i++) begin
                if (slot_ok(i) && wb_adr_i == `CMIO_ADR_POL) begin
                    next_cfg_pol[i] = wb_dat_i[i]; // [RQ5]
                end
                if (slot_ok(i) && wb_adr_i == `CMIO_ADR_OUT) begin
                    next_gp_out[i] = wb_dat_i[i]; // [RQ5]
                end
            end
            if (wb_adr_i == `CMIO_ADR_CTRL) begin
                next_jog_en = wb_dat_i[`CMIO_CTRL_JOG_BIT]; // [RQ13]
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        next_ack = req;
        next_rdat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `CMIO_ADR_SETUP: begin
                    next_rdat[`CMIO_SU_PT_MSB:`CMIO_SU_PT_LSB] = last_pt;
                    if (rd_slot[3]) begin
                        next_rdat[`CMIO_SU_FN_MSB:`CMIO_SU_FN_LSB] = cfg_fn[rd_slot[2:0]];
                        next_rdat[`CMIO_SU_POL_BIT] = cfg_pol[rd_slot[2:0]];
                        next_rdat[`CMIO_SU_SRC_BIT] = src_ok[rd_slot[2:0]];
                    end
                end
                `CMIO_ADR_POL: next_rdat[NPT-1:0] = cfg_pol;
                `CMIO_ADR_OUT: next_rdat[NPT-1:0] = gp_out;
                `CMIO_ADR_IN: next_rdat[NPT-1:0] = fn_hit(`CMIO_FN_GP_IN, val); // [RQ7]
                `CMIO_ADR_CTRL: next_rdat[`CMIO_CTRL_JOG_BIT] = jog_en;
                `CMIO_ADR_STAT: next_rdat[2:0] = {pause_o, REMOTE_ENC, ENHANCED};
                default: next_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NPT; i++) begin
                cfg_fn[i] <= `CMIO_FN_RST;
            end
            cfg_pol <= `CMIO_POL_RST;
            cfg_src <= '0;
            gp_out <= '0;
            jog_en <= 1'b0;
            last_pt <= 4'h0;
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
        end else begin
            cfg_fn <= next_cfg_fn;
            cfg_pol <= next_cfg_pol;
            cfg_src <= next_cfg_src;
            gp_out <= next_gp_out;
            jog_en <= next_jog_en;
            last_pt <= next_last_pt;
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    ack_timing_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o) // [RQ5]
        else $error("ack not one cycle after request");

    start_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (|fn_hit(`CMIO_FN_START, rise)) |=> (start_o && start_addr_o == 8'h01)) // [RQ10]
        else $error("start input did not start program one");

    sstop_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (|fn_hit(`CMIO_FN_SSTOP, rise)) |=> (soft_stop_o && !pause_o)) // [RQ11]
        else $error("soft stop not raised");

    pause_toggle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (|fn_hit(`CMIO_FN_PAUSE, rise) && !next_sstop_q && !next_brk_q)
        |=> pause_o != $past(pause_o)) // [RQ12]
        else $error("pause activation did not toggle");

    jog_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !jog_en |-> !jog_pos_o && !jog_neg_o) // [RQ13]
        else $error("jog without enable");

    break_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        break_o |=> !break_o) // [RQ14]
        else $error("break held longer than a pulse");

    enc_bank_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!ENHANCED || REMOTE_ENC) |-> io_pin_oe_o[NPT-1:`CMIO_BANK_PTS] == '0) // [RQ15]
        else $error("reserved bank driven");

    home_lvl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cfg_fn[0] == `CMIO_FN_HOME && val[0]) |-> home_o) // [RQ8]
        else $error("home point active but home low");

    gp_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == `CMIO_ADR_IN && cfg_fn[0] == `CMIO_FN_GP_IN)
        |=> wb_dat_o[0] == $past(val[0])) // [RQ7]
        else $error("input register wrong");
endmodule
`default_nettype wire

// File: cmio_pin_model.sv
// model of the sensors, switches and loads wired to the io pins
`timescale 1ns/1ps
`default_nettype none
module cmio_pin_model #(
    parameter int N = 8 // pin count
) (
    input wire logic [N-1:0] sw_i, // level the external source applies
    input wire logic [N-1:0] drv_i, // device drive value
    input wire logic [N-1:0] oe_i, // device drive enable
    output logic [N-1:0] pin_o // resolved wire level
);
    // ----------------------------------------------------------------
    // wire resolution
    // ----------------------------------------------------------------
    // a driven point follows the device; an undriven one follows the sensor
    assign pin_o = (oe_i & drv_i) | (~oe_i & sw_i);
endmodule
`default_nettype wire

// File: test_configurable_motion_io_points.sv
// self-checking bench for the motion io points
`timescale 1ns/1ps
`default_nettype none
`include "cmio_regs.svh"
module test_configurable_motion_io_points;
    import cmio_pkg::*;
    logic ref_clk_i, rst_i, cyc, stb, we, ack;
    logic home, lim_p, lim_n, st, ss, pause, jog_p, jog_n, brk;
    cmio_adr_t adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, q;
    logic [7:0] sw, pin_lvl, pin_drv, pin_oe, st_addr;
    logic [1:0] n_st = 2'h0, n_ss = 2'h0, n_brk = 2'h0;
    logic mov = 1'b0;
    int miscompares = 0, n_tests = 0, wd = 0;
    cmio_fn_t fns [8] = '{5'h01, 5'h02, 5'h03, 5'h07, 5'h08, 5'h04, 5'h05, 5'h0b};

    cmio_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .io_pin_i(pin_lvl), .io_pin_o(pin_drv), .io_pin_oe_o(pin_oe),
        .moving_i(mov), .fault_i(1'b0), .stall_i(1'b0), .vel_chg_i(1'b0),
        .home_o(home), .limit_pos_o(lim_p), .limit_neg_o(lim_n), .start_o(st),
        .start_addr_o(st_addr), .soft_stop_o(ss), .pause_o(pause), .jog_pos_o(jog_p),
        .jog_neg_o(jog_n), .break_o(brk));
    cmio_pin_model #(.N(8)) pins (.sw_i(sw), .drv_i(pin_drv), .oe_i(pin_oe), .pin_o(pin_lvl));

    // ----------------------------------------------------------------
    // clock, pulse counters and watchdog
    // ----------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // counting high cycles also catches pulses longer than one cycle
    always @(posedge ref_clk_i) begin
        if (st === 1'b1) n_st <= n_st + 2'h1;
        if (ss === 1'b1) n_ss <= n_ss + 2'h1;
        if (brk === 1'b1) n_brk <= n_brk + 2'h1;
        wd = wd + 1;
        if (wd == 20000) begin
            miscompares++;
            close_out;
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input cmio_adr_t a, input logic [31:0] d);
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        @(posedge ref_clk_i);
        while (ack !== 1'b1) @(posedge ref_clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input cmio_adr_t a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input cmio_adr_t a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // pulse counters have taken a pin edge four clocks later
    task automatic settle;
        repeat (5) @(posedge ref_clk_i);
    endtask
    function automatic logic [31:0] su(input logic [3:0] pt, input cmio_fn_t fn,
        input logic pol, input logic src);
        su = {11'h0, src, 3'h0, pol, 3'h0, fn, 4'h0, pt};
    endfunction

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
        sw = 8'h00;
        rst_i = 1'b1;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(`CMIO_ADR_STAT, 32'h1);
        rd(`CMIO_ADR_POL, 32'hff);
        rd(`CMIO_ADR_CTRL, 32'h0);
        rd(8'h20, 32'h0);
        $display("test reset done");
        sw <= 8'ha5;
        settle;
        rd(`CMIO_ADR_IN, 32'ha5);
        wr(`CMIO_ADR_POL, 32'h0);
        rd(`CMIO_ADR_IN, 32'h5a);
        wr(`CMIO_ADR_SETUP, su(4'h0, 5'h00, 1'b1, 1'b0));
        rd(`CMIO_ADR_IN, 32'ha5);
        sw <= 8'h00;
        settle;
        $display("test polarity done");
        wr(`CMIO_ADR_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            wr(`CMIO_ADR_SETUP, su((i < 4) ? 4'(i + 1) : 4'(i + 5), fns[i], 1'b1, 1'b0));
        end
        for (int i = 0; i < 8; i++) begin
            sw[i] <= 1'b1;
            settle;
            chk({jog_n, jog_p, lim_n, lim_p, home}, (i < 5) ? (1 << i) : 0);
            chk({n_brk, n_ss, n_st}, {1'b0, i >= 7, 1'b0, i >= 6, 1'b0, i >= 5});
            sw[i] <= 1'b0;
            settle;
        end
        chk(st_addr, 32'h1);
        wr(`CMIO_ADR_CTRL, 32'h0);
        sw[3] <= 1'b1;
        settle;
        chk(jog_p, 1'b0);
        sw <= 8'h00;
        settle;
        $display("test functions done");
        wr(`CMIO_ADR_SETUP, su(4'h1, 5'h06, 1'b1, 1'b0));
        sw[0] <= 1'b1;
        settle;
        chk(pause, 1'b1);
        rd(`CMIO_ADR_STAT, 32'h5);
        sw[0] <= 1'b0;
        settle;
        sw[0] <= 1'b1;
        settle;
        chk(pause, 1'b0);
        sw <= 8'h00;
        settle;
        wr(`CMIO_ADR_SETUP, su(4'h5, 5'h01, 1'b1, 1'b0));
        rd(`CMIO_ADR_SETUP, su(4'h1, 5'h06, 1'b1, 1'b0));
        $display("test pause done");
        wr(`CMIO_ADR_SETUP, su(4'h9, 5'h10, 1'b1, 1'b1));
        wr(`CMIO_ADR_OUT, 32'h10);
        chk({pin_oe[4], pin_drv[4]}, 2'b11);
        rd(`CMIO_ADR_SETUP, su(4'h9, 5'h10, 1'b1, 1'b1));
        wr(`CMIO_ADR_SETUP, su(4'h9, 5'h10, 1'b0, 1'b1));
        chk({pin_oe[4], pin_drv[4]}, 2'b10);
        wr(`CMIO_ADR_SETUP, su(4'ha, 5'h11, 1'b1, 1'b1));
        mov <= 1'b1;
        @(posedge ref_clk_i);
        chk({pin_oe[5], pin_drv[5]}, 2'b11);
        wr(`CMIO_ADR_SETUP, su(4'hb, 5'h12, 1'b1, 1'b0));
        chk({pin_oe[6], pin_drv[6]}, 2'b10);
        $display("test outputs done");
        close_out;
    end
endmodule
`default_nettype wire
